// >>> pkg/cpb_cfg.svh
/*
 * constants of the context control register and the page table pointer buffer:
 * addresses, field positions, reset value and periodic tick timing.
 * assumes it is included by its bare name wherever these values are needed.
 */
`ifndef CPB_CFG_SVH
`define CPB_CFG_SVH

// ------------------------------------------------------------------
// address map
// ------------------------------------------------------------------
`define CPB_CTX_ADDR 32'h50000000
`define CPB_PTP_BASE 32'h60000000
`define CPB_PTP_LAST 32'h6FE00000
`define CPB_PTP_REGION 4'h6
`define CPB_PTP_IDX_LSB 21
`define CPB_PTP_IDX_MSB 27

// ------------------------------------------------------------------
// context control fields and reset value
// ------------------------------------------------------------------
`define CPB_CTX_DIAG_BIT 7
`define CPB_CTX_IPI_MSB 6
`define CPB_CTX_IPI_LSB 5
`define CPB_CTX_TICK_BIT 4
`define CPB_CTX_PARITY_BIT 3
`define CPB_CTX_NUM_MSB 2
`define CPB_CTX_NUM_LSB 0
`define CPB_CTX_RESET 8'h00

// ------------------------------------------------------------------
// periodic clock interrupt timing
// ------------------------------------------------------------------
`define CPB_CLK_HZ 50000000
`define CPB_TICK_HZ 60

`endif

// >>> pkg/cpb_pkg.sv
/*
 * types shared by the context register block and its pointer buffer.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package cpb_pkg;
	// byte of the context control register
	typedef logic [7:0] cpb_byte_type;
	// one page table pointer
	typedef logic [11:0] cpb_ptp_type;
	// pointer index inside the buffer
	typedef logic [6:0] cpb_index_type;
	// what a bus request hits
	typedef enum logic [1:0] {
		CPB_HIT_NONE = 2'b00,
		CPB_HIT_CTX = 2'b01,
		CPB_HIT_PTP = 2'b10
	} cpb_hit_type;
endpackage

// >>> core/cpb_ptp_store.sv
/*
 * page table pointer storage: one write port and two registered read ports,
 * one for the processor bus and one for the translation lookup.
 * assumes a single clock and a synchronous active high reset.
 */
`timescale 1ns/1ps
module cpb_ptp_store
	import cpb_pkg::*;
#(
	parameter int DEPTH = 128,
	parameter int WIDTH = 12
) (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic write_i,
	input wire logic [$clog2(DEPTH)-1:0] write_index_i,
	input wire logic [WIDTH-1:0] write_data_i,
	input wire logic [$clog2(DEPTH)-1:0] bus_index_i,
	output logic [WIDTH-1:0] bus_data_o,
	input wire logic [$clog2(DEPTH)-1:0] lookup_index_i,
	output logic [WIDTH-1:0] lookup_data_o
);
	// pointer array of the current context
	logic [WIDTH-1:0] entries [DEPTH];

	// ------------------------------------------------------------------
	// write port
	// ------------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (write_i) begin
			entries[write_index_i] <= write_data_i;
		end
	end

	// ------------------------------------------------------------------
	// read ports, both registered
	// ------------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			bus_data_o <= '0;
			lookup_data_o <= '0;
		end else begin
			bus_data_o <= entries[bus_index_i];
			lookup_data_o <= entries[lookup_index_i];
		end
	end
endmodule

// >>> core/cpb_context_register.sv
/*
 * context control register, board status byte readback and page table pointer
 * buffer decode, with the periodic clock tick gate and parity error gate.
 * assumes a processor bus on the same clock making one-cycle requests, and
 * jumper pins that arrive asynchronously.
 */
// Overview of operation
// (RULE1) write-only context byte at 50000000
// (RULE2) reads there return the board status byte
// (RULE3) diagnostic bit stays zero until written
// (RULE4) indicator lit while diagnostic bit is zero
// (RULE5) bits six-five plus jumper choose IPI address
// (RULE6) bit four enables 60 Hz clock interrupt
// (RULE7) bit three enables parity checking
// (RULE8) bits two-zero give the current context
// (RULE9) buffer holds 128 twelve-bit pointers
// (RULE10) pointers at 2 MB strides from 60000000
// (RULE11) reset clears the whole context byte
`timescale 1ns/1ps
`include "cpb_cfg.svh"
module cpb_context_register
	import cpb_pkg::*;
#(
	parameter int TICK_CYCLES = `CPB_CLK_HZ / `CPB_TICK_HZ,
	parameter int PTP_DEPTH = 128,
	parameter int PTP_WIDTH = 12
) (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic req_i,
	input wire logic write_i,
	input wire logic system_mode_i,
	input wire logic [31:0] addr_i,
	input wire logic [15:0] wdata_i,
	output logic ack_o,
	output logic berr_o,
	output logic [15:0] rdata_o,
	input wire logic [7:0] status_jumpers_i,
	input wire logic ipi_select_jumper_i,
	output logic diag_indicator_o,
	output logic [2:0] ipi_addr_select_o,
	output logic clock_irq_o,
	output logic parity_check_enable_o,
	input wire logic parity_fault_i,
	output logic parity_error_o,
	output logic [2:0] context_o,
	input wire logic [6:0] lookup_index_i,
	output logic [PTP_WIDTH-1:0] lookup_ptp_o
);
	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	cpb_byte_type context_control; // the write-only control byte
	logic [8:0] sync_a; // first pin stage
	logic [8:0] sync_b; // second pin stage
	logic [8:0] sync_c; // third pin stage
	logic [8:0] pins_stable; // accepted pin levels
	logic [19:0] tick_count; // divider toward the periodic tick
	logic tick; // one-cycle periodic enable
	cpb_hit_type hit; // decode of the current request
	cpb_hit_type hit_q; // decode of the answered request
	logic rd_pending; // a read answer is due
	logic ptp_write; // pointer store write strobe
	cpb_index_type ptp_index; // pointer index from the address
	logic [PTP_WIDTH-1:0] ptp_rd; // pointer read data
	cpb_byte_type board_status_byte; // status byte from the accepted pin levels

	// ------------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------------
	// pointer index is the address above the 2 MB stride
	assign ptp_index = addr_i[`CPB_PTP_IDX_MSB:`CPB_PTP_IDX_LSB]; // RULE10
	always_comb begin
		hit = CPB_HIT_NONE;
		// only system mode reaches the byte I/O space and the buffer
		if (system_mode_i) begin
			if (addr_i == `CPB_CTX_ADDR) begin
				hit = CPB_HIT_CTX; // RULE1
			end else if (addr_i[31:28] == `CPB_PTP_REGION &&
					addr_i[`CPB_PTP_IDX_LSB-1:0] == '0) begin
				hit = CPB_HIT_PTP; // RULE10
			end
		end
	end
	// a pointer write from the bus
	assign ptp_write = req_i && write_i && hit == CPB_HIT_PTP;

	// ------------------------------------------------------------------
	// context control register
	// ------------------------------------------------------------------
	// writes land whole; reset clears every field
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			context_control <= `CPB_CTX_RESET; // RULE11 RULE3
		end else if (req_i && write_i && hit == CPB_HIT_CTX) begin
			context_control <= wdata_i[7:0]; // RULE1
		end
	end

	// ------------------------------------------------------------------
	// jumper pins: three stages, bit zero while stages two and three differ, stage three once they agree
	// ------------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			sync_a <= '0;
			sync_b <= '0;
			sync_c <= '0;
		end else begin
			sync_a <= {ipi_select_jumper_i, status_jumpers_i};
			sync_b <= sync_a;
			sync_c <= sync_b;
		end
	end
	// each bit reads zero while stages two and three differ, then takes stage three once steady
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			pins_stable <= '0;
		end else begin
			pins_stable <= (pins_stable & ~(sync_b ^ sync_c)) | (sync_c & ~(sync_b ^ sync_c));
		end
	end
	// status byte that a read returns
	assign board_status_byte = pins_stable[7:0]; // RULE2

	// ------------------------------------------------------------------
	// bus answer: one cycle after each request
	// ------------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			ack_o <= 1'b0;
			berr_o <= 1'b0;
			rd_pending <= 1'b0;
			hit_q <= CPB_HIT_NONE;
		end else begin
			// mapped requests acknowledge, unmapped ones fault
			ack_o <= req_i && hit != CPB_HIT_NONE;
			berr_o <= req_i && hit == CPB_HIT_NONE;
			rd_pending <= req_i && !write_i && hit != CPB_HIT_NONE;
			hit_q <= req_i ? hit : CPB_HIT_NONE;
		end
	end
	// status byte must be held from the request edge
	cpb_byte_type status_q; // status byte at the request edge
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			status_q <= '0;
		end else if (req_i) begin
			status_q <= board_status_byte; // RULE2
		end
	end
	// read data steers from the answered decode
	always_comb begin
		rdata_o = 16'h0000;
		if (rd_pending) begin
			unique case (hit_q)
				CPB_HIT_CTX: rdata_o = {8'h00, status_q}; // RULE2
				CPB_HIT_PTP: rdata_o = {{(16-PTP_WIDTH){1'b0}}, ptp_rd}; // RULE9
				CPB_HIT_NONE: rdata_o = 16'h0000;
				default: rdata_o = 16'h0000;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// pointer buffer
	// ------------------------------------------------------------------
	cpb_ptp_store #(
		.DEPTH(PTP_DEPTH),
		.WIDTH(PTP_WIDTH)
	) ptp_store (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.write_i(ptp_write), // RULE9
		.write_index_i(ptp_index),
		.write_data_i(wdata_i[PTP_WIDTH-1:0]),
		.bus_index_i(ptp_index),
		.bus_data_o(ptp_rd),
		.lookup_index_i(lookup_index_i),
		.lookup_data_o(lookup_ptp_o)
	);

	// ------------------------------------------------------------------
	// periodic tick divider
	// ------------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			tick_count <= '0;
			tick <= 1'b0;
		end else if (tick_count == 20'(TICK_CYCLES - 1)) begin
			tick_count <= '0;
			tick <= 1'b1;
		end else begin
			tick_count <= tick_count + 20'h00001;
			tick <= 1'b0;
		end
	end
	// tick reaches the interrupt only while enabled
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			clock_irq_o <= 1'b0;
		end else begin
			clock_irq_o <= tick && context_control[`CPB_CTX_TICK_BIT]; // RULE6
		end
	end

	// ------------------------------------------------------------------
	// parity gate
	// ------------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			parity_error_o <= 1'b0;
		end else begin
			parity_error_o <= parity_fault_i && context_control[`CPB_CTX_PARITY_BIT]; // RULE7
		end
	end

	// ------------------------------------------------------------------
	// field outputs
	// ------------------------------------------------------------------
	assign diag_indicator_o = !context_control[`CPB_CTX_DIAG_BIT]; // RULE4
	assign ipi_addr_select_o = {pins_stable[8],
		context_control[`CPB_CTX_IPI_MSB:`CPB_CTX_IPI_LSB]}; // RULE5
	assign parity_check_enable_o = context_control[`CPB_CTX_PARITY_BIT]; // RULE7
	assign context_o = context_control[`CPB_CTX_NUM_MSB:`CPB_CTX_NUM_LSB]; // RULE8

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);

	AST_CTX_WRITE: assert property ( // RULE1
		req_i && write_i && system_mode_i && addr_i == `CPB_CTX_ADDR
		|=> context_control == $past(wdata_i[7:0]) && ack_o)
		else $error("context write not stored");
	AST_STATUS_READ: assert property ( // RULE2
		req_i && !write_i && system_mode_i && addr_i == `CPB_CTX_ADDR
		|=> ack_o && rdata_o == {8'h00, $past(board_status_byte)})
		else $error("status byte read wrong");
	AST_RESET_CLEAR: assert property ( // RULE11
		$past(reset_i) |-> context_control == 8'h00 && diag_indicator_o)
		else $error("context byte not cleared by reset");
	AST_DIAG_HOLD: assert property ( // RULE3
		!context_control[7] && !(req_i && write_i && hit == CPB_HIT_CTX)
		|=> !context_control[7])
		else $error("diagnostic bit set without a write");
	AST_DIAG_LED: assert property ( // RULE4
		diag_indicator_o != context_control[7])
		else $error("indicator does not follow diagnostic bit");
	AST_IPI_SEL: assert property ( // RULE5
		ipi_addr_select_o[1:0] == context_control[6:5] &&
		ipi_addr_select_o[2] == pins_stable[8])
		else $error("interrupt address select wrong");
	AST_TICK_GATE: assert property ( // RULE6
		clock_irq_o |-> $past(context_control[4]) && $past(tick))
		else $error("clock interrupt while disabled");
	AST_PARITY_GATE: assert property ( // RULE7
		$past(parity_fault_i) && $past(context_control[3]) |-> parity_error_o)
		else $error("parity error lost while checking enabled");
	AST_CONTEXT_NUM: assert property ( // RULE8
		context_o == context_control[2:0])
		else $error("context number wrong");
	AST_PTP_ROUNDTRIP: assert property ( // RULE9
		ptp_write ##1 (req_i && !write_i && hit == CPB_HIT_PTP &&
			ptp_index == $past(ptp_index))
		|=> rdata_o[11:0] == $past(wdata_i[11:0], 2))
		else $error("pointer not read back");
	AST_UNMAPPED: assert property ( // RULE10
		req_i && (!system_mode_i || (addr_i[31:28] == 4'h6 && addr_i[20:0] != '0))
		|=> berr_o && !ack_o)
		else $error("off-stride access not refused");

	COV_CTX_WRITE: cover property (req_i && write_i && hit == CPB_HIT_CTX);
	COV_PTP_LAST: cover property (req_i && !write_i && addr_i == `CPB_PTP_LAST);
	COV_CLOCK_IRQ: cover property (clock_irq_o);
	COV_PTP_BACK_TO_BACK: cover property (ptp_write ##1 (req_i && !write_i && hit == CPB_HIT_PTP));
endmodule

// >>> testbench/cpb_cpu_model.sv
/*
 * processor core model: issues system or user mode byte accesses on the
 * same-clock request/answer bus of the context register block.
 * assumes the answer arrives one cycle after the request edge.
 */
`timescale 1ns/1ps
module cpb_cpu_model (
	input wire logic clock_i,
	input wire logic ack_i,
	input wire logic berr_i,
	input wire logic [15:0] rdata_i,
	output logic req_o,
	output logic write_o,
	output logic system_mode_o,
	output logic [31:0] addr_o,
	output logic [15:0] wdata_o
);
	// ------------------------------------------------------------------
	// idle bus
	// ------------------------------------------------------------------
	initial begin
		req_o = 1'b0;
		write_o = 1'b0;
		system_mode_o = 1'b1;
		addr_o = 32'h00000000;
		wdata_o = 16'h0000;
	end

	// ------------------------------------------------------------------
	// one access: request pulse, then take the answer cycle
	// ------------------------------------------------------------------
	task automatic access(input logic w, input logic sm, input logic [31:0] a,
		input logic [15:0] d, output logic [1:0] resp, output logic [15:0] rd);
		@(posedge clock_i);
		#1;
		req_o = 1'b1;
		write_o = w;
		system_mode_o = sm;
		addr_o = a;
		wdata_o = d;
		@(posedge clock_i);
		#1;
		// released lines show the inverse so stale values never pass
		req_o = 1'b0;
		write_o = ~w;
		addr_o = ~a;
		wdata_o = ~d;
		resp = {berr_i, ack_i};
		rd = rdata_i;
	endtask

	// ------------------------------------------------------------------
	// back-to-back pointer write and read of one address
	// ------------------------------------------------------------------
	task automatic write_read(input logic [31:0] a, input logic [15:0] d,
		output logic [1:0] wresp, output logic [17:0] rresp);
		@(posedge clock_i);
		#1;
		req_o = 1'b1;
		write_o = 1'b1;
		system_mode_o = 1'b1;
		addr_o = a;
		wdata_o = d;
		@(posedge clock_i);
		#1;
		// write answer stands now; the read request follows with no gap
		wresp = {berr_i, ack_i};
		write_o = 1'b0;
		wdata_o = ~d;
		@(posedge clock_i);
		#1;
		req_o = 1'b0;
		write_o = 1'b1;
		addr_o = ~a;
		rresp = {berr_i, ack_i, rdata_i};
	endtask
endmodule

// >>> testbench/tb_context_register_ptp_buffer.sv
/*
 * self-checking bench of the context register and pointer buffer.
 * assumes the processor model drives the bus and the bench drives the rest.
 */
`timescale 1ns/1ps
module tb_context_register_ptp_buffer;
	import cpb_pkg::*;
	// one context write per row and the outputs it should give
	typedef struct packed {logic [7:0] data; logic jmp; logic [7:0] exp;} cpb_row_type;
	cpb_row_type rows [8] = '{'{8'h80, 1'b0, 8'h00}, '{8'h01, 1'b1, 8'hC1},
		'{8'h2A, 1'b0, 8'h9A}, '{8'hCB, 1'b1, 8'h6B}, '{8'h74, 1'b0, 8'hB4},
		'{8'hE5, 1'b1, 8'h75}, '{8'h1E, 1'b0, 8'h8E}, '{8'h9F, 1'b1, 8'h4F}};
	logic [6:0] idx [4] = '{7'h00, 7'h01, 7'h40, 7'h7F};
	logic clock_i, reset_i, req, wr, sm, ack, berr;
	logic [31:0] addr;
	logic [15:0] wdata, rdata, rd;
	logic [17:0] rdr;
	logic [7:0] status_jumpers_i;
	logic ipi_select_jumper_i, parity_fault_i, parity_error_o, clock_irq_o;
	logic diag_indicator_o, parity_check_enable_o;
	logic [2:0] ipi_addr_select_o, context_o;
	logic [6:0] lookup_index_i;
	logic [11:0] lookup_ptp_o;
	logic [1:0] resp;
	int n_errors = 0;
	int total_checks = 0;

	// ------------------------------------------------------------------
	// clock, partner and design
	// ------------------------------------------------------------------
	initial begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end
	cpb_cpu_model cpu (.clock_i(clock_i), .ack_i(ack), .berr_i(berr), .rdata_i(rdata),
		.req_o(req), .write_o(wr), .system_mode_o(sm), .addr_o(addr), .wdata_o(wdata));
	cpb_context_register #(.TICK_CYCLES(16)) DUT (.clock_i(clock_i), .reset_i(reset_i),
		.req_i(req), .write_i(wr), .system_mode_i(sm), .addr_i(addr), .wdata_i(wdata),
		.ack_o(ack), .berr_o(berr), .rdata_o(rdata), .status_jumpers_i(status_jumpers_i),
		.ipi_select_jumper_i(ipi_select_jumper_i), .diag_indicator_o(diag_indicator_o),
		.ipi_addr_select_o(ipi_addr_select_o), .clock_irq_o(clock_irq_o),
		.parity_check_enable_o(parity_check_enable_o), .parity_fault_i(parity_fault_i),
		.parity_error_o(parity_error_o), .context_o(context_o),
		.lookup_index_i(lookup_index_i), .lookup_ptp_o(lookup_ptp_o));

	// ------------------------------------------------------------------
	// compare, tick count and closing
	// ------------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// counts tick pulses over 64 cycles, four tick periods
	task automatic count_ticks(output logic [31:0] cnt);
		cnt = 32'h00000000;
		repeat (64) begin
			@(posedge clock_i);
			#1;
			if (clock_irq_o === 1'b1) cnt++;
		end
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// watchdog well beyond the roughly 700 cycles of the run
	initial begin
		#200000;
		n_errors++;
		finish_test();
	end

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		logic [31:0] cnt;
		reset_i = 1'b1;
		status_jumpers_i = 8'h00;
		ipi_select_jumper_i = 1'b0;
		parity_fault_i = 1'b0;
		lookup_index_i = 7'h00;
		repeat (10) @(posedge clock_i);
		#1;
		reset_i = 1'b0;
		check({diag_indicator_o, ipi_addr_select_o, parity_check_enable_o, context_o}, 8'h80);
		check({ack, berr, rdata, clock_irq_o, parity_error_o, lookup_ptp_o}, 32'h00000000);
		count_ticks(cnt);
		check(cnt, 32'h00000000);
		// table of context writes, each read back through its outputs
		for (int i = 0; i < 8; i++) begin
			ipi_select_jumper_i = rows[i].jmp;
			status_jumpers_i = ~rows[i].data;
			repeat (6) @(posedge clock_i);
			#1;
			cpu.access(1'b1, 1'b1, 32'h50000000, {8'h00, rows[i].data}, resp, rd);
			check(resp, 2'b01);
			check({diag_indicator_o, ipi_addr_select_o, parity_check_enable_o, context_o}, rows[i].exp);
			cpu.access(1'b0, 1'b1, 32'h50000000, 16'h0000, resp, rd);
			check({resp, rd}, {2'b01, 8'h00, ~rows[i].data});
			parity_fault_i = 1'b1;
			@(posedge clock_i);
			#1;
			parity_fault_i = 1'b0;
			check(parity_error_o, rows[i].data[3]);
			count_ticks(cnt);
			check(cnt, rows[i].data[4] ? 32'h00000004 : 32'h00000000);
		end
		// pointer buffer ends and middle, by bus and by lookup
		for (int i = 0; i < 4; i++) begin
			cpu.access(1'b1, 1'b1, {4'h6, idx[i], 21'h000000}, {9'h150, idx[i]}, resp, rd);
			check(resp, 2'b01);
		end
		for (int i = 0; i < 4; i++) begin
			cpu.access(1'b0, 1'b1, {4'h6, idx[i], 21'h000000}, 16'h0000, resp, rd);
			check({resp, rd}, {2'b01, 4'h0, 5'h10, idx[i]});
			lookup_index_i = idx[i];
			@(posedge clock_i);
			#1;
			check(lookup_ptp_o, {5'h10, idx[i]});
		end
		// write and read back of one pointer in consecutive cycles
		cpu.write_read(32'h64A00000, 16'h0ABC, resp, rdr);
		check(resp, 2'b01);
		check(rdr, {2'b01, 16'h0ABC});
		// user mode write, unmapped read and unaligned pointer are refused
		cpu.access(1'b1, 1'b0, 32'h50000000, 16'h0000, resp, rd);
		check({resp, rd}, {2'b10, 16'h0000});
		cpu.access(1'b0, 1'b1, 32'h54000000, 16'h0000, resp, rd);
		check({resp, rd}, {2'b10, 16'h0000});
		cpu.access(1'b1, 1'b1, 32'h60100000, 16'h0000, resp, rd);
		check(resp, 2'b10);
		check({diag_indicator_o, context_o}, 4'h7);
		// second reset in mid-run clears the byte again
		@(posedge clock_i);
		#1;
		reset_i = 1'b1;
		ipi_select_jumper_i = 1'b0;
		repeat (2) @(posedge clock_i);
		#1;
		reset_i = 1'b0;
		check({diag_indicator_o, ipi_addr_select_o[1:0], parity_check_enable_o, context_o}, 7'h40);
		finish_test();
	end
endmodule
